// File: logic/occ_pkg.sv
package occ_pkg;

   // ------------------------------------------------------------
   // Register map (byte addresses, one aligned word each)
   // ------------------------------------------------------------
   localparam logic [3:0]  ADDR_CTRL_ONE  = 4'h0;  // compare_control_one
   localparam logic [3:0]  ADDR_CTRL_TWO  = 4'h4;  // compare_control_two (status)
   localparam logic [3:0]  ADDR_PRIMARY   = 4'h8;  // primary_compare_value
   localparam logic [3:0]  ADDR_SECONDARY = 4'hc;  // secondary_compare_value

   // ------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------
   localparam int          MODE_LSB       = 0;
   localparam int          MODE_MSB       = 2;
   localparam int          TRIG_CLR_BIT   = 3;
   localparam int          TRIG_STAT_BIT  = 6;
   localparam int          PIN_STAT_BIT   = 0;
   localparam int          ARMED_BIT      = 1;
   localparam int          SRC_LSB        = 8;
   localparam int          SRC_MSB        = 9;
   localparam logic [15:0] CTRL_RESET     = 16'h0000;
   localparam logic [15:0] VALUE_RESET    = 16'h0000;
   localparam logic [15:0] TIMER_ZERO     = 16'h0000;

   // ------------------------------------------------------------
   // Modes
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      OCC_OFF        = 3'h0,
      OCC_SHOT_HIGH  = 3'h1,
      OCC_SHOT_LOW   = 3'h2,
      OCC_TOGGLE     = 3'h3,
      OCC_DUAL_SHOT  = 3'h4,
      OCC_DUAL_CONT  = 3'h5,
      OCC_PWM_EDGE   = 3'h6,
      OCC_PWM_CENTER = 3'h7
   } occ_mode_e;

   // Trigger output index feeding channels one to four
   localparam logic [2:0]  TRIG_OUT_BASE  = 3'h4;

endpackage : occ_pkg

// File: logic/occ_cmp_if.sv
`timescale 1ns/100ps
// Active compare values and match strobes between core and matcher
interface occ_cmp_if;
   logic [15:0] active_primary;
   logic [15:0] active_secondary;
   logic        hit_primary;
   logic        hit_secondary;
   logic        hit_zero;
   modport core    (output active_primary, output active_secondary,
                    input hit_primary, input hit_secondary, input hit_zero);
   modport matcher (input active_primary, input active_secondary,
                    output hit_primary, output hit_secondary, output hit_zero);
endinterface : occ_cmp_if

// File: logic/occ_matcher.sv
`timescale 1ns/100ps
module occ_matcher
   import occ_pkg::*;
(
   // Timer
   input  wire logic [15:0] timer_count_in,
   // Compare values and matches
   occ_cmp_if.matcher       cmp
);
   import occ_pkg::*;

   // ------------------------------------------------------------
   // Equality compares, evaluated every clock
   // ------------------------------------------------------------
   assign cmp.hit_primary   = (timer_count_in == cmp.active_primary);
   assign cmp.hit_secondary = (timer_count_in == cmp.active_secondary);
   assign cmp.hit_zero      = (timer_count_in == TIMER_ZERO);

endmodule : occ_matcher

// File: logic/occ_clock_select.sv
`timescale 1ns/100ps
module occ_clock_select
   import occ_pkg::*;
#(
   parameter int CHANNEL = 0                 // 0..3 for channels one..four
)(
   // Trigger generator outputs
   input  wire logic [15:0] trig_outputs_in,
   // Selected clock pulse
   output logic             trig_pulse_out
);
   import occ_pkg::*;

   // ------------------------------------------------------------
   // One fixed trigger output per channel: four..seven
   // ------------------------------------------------------------
   localparam logic [3:0] TAP = {1'b0, TRIG_OUT_BASE} + 4'(CHANNEL);
   assign trig_pulse_out = trig_outputs_in[TAP];

endmodule : occ_clock_select

// File: logic/occ_channel.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Functional notes
// - Center PWM: high at primary, low secondary
// - Edge PWM: high at zero, low primary
// - Dual continuous: start low, alternate toggles
// - Dual single-shot: start low, one pulse
// - Single compare: toggle every primary match
// - Single-shot low: start high, primary drives low
// - Single-shot high: start low, primary drives high
// - Mode zero disables channel, output held
// - Clear mode set: secondary match clears status
// - Clear mode zero: only software clears status
// - Compare values double-buffered in PWM only
// - Channel n uses trigger output n+3
// ------------------------------------------------------------
module occ_channel
   import occ_pkg::*;
#(
   parameter int CHANNEL = 0
)(
   // Clock and reset
   input  wire logic              clock_in,
   input  wire logic              rstn_in,
   // Avalon-MM slave
   input  wire logic [3:0]        avs_address_in,
   input  wire logic              avs_read_in,
   input  wire logic              avs_write_in,
   input  wire logic [31:0]       avs_writedata_in,
   input  wire logic [3:0]        avs_byteenable_in,
   output logic [31:0]            avs_readdata_out,
   output logic                   avs_waitrequest_out,
   // Timer and trigger generator
   input  wire logic [15:0]       timer_count_in,
   input  wire logic [15:0]       trig_outputs_in,
   // Pin and status
   output logic                   compare_output_pin_out,
   output logic                   trigger_status_flag_out,
   output logic                   trigger_clock_out
);
   import occ_pkg::*;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [15:0] ctrl_ff;
   logic [15:0] primary_ff;
   logic [15:0] secondary_ff;
   logic [15:0] act_primary_ff;
   logic [15:0] act_secondary_ff;
   logic        pin_ff;
   logic        nxt_pin;
   logic        armed_ff;
   logic        nxt_armed;
   logic        phase_ff;                    // Dual modes: 0 waits primary, 1 secondary
   logic        nxt_phase;
   logic        status_ff;
   logic        nxt_status;
   logic        ack_ff;
   logic        wait_ff;                     // Registered waitrequest, high while idle
   logic [31:0] rdata_ff;
   logic        trig_ff;
   logic [2:0]  prev_mode_ff;

   occ_cmp_if cmp ();

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   // A request is taken while no answer is pending; the answer edge follows one clock later.
   // Writes land on the answer edge, where the master samples waitrequest low, so a write
   // never takes effect while the master still treats the transfer as open.
   wire         acc_go      = (avs_read_in | avs_write_in) & ~ack_ff;
   wire         wr_go       = avs_write_in & ack_ff;
   // Registers are 16 bits wide: only lanes 0 and 1 matter
   wire         lo_en       = avs_byteenable_in[0];
   wire         hi_en       = avs_byteenable_in[1];
   wire         sel_ctrl    = (avs_address_in == ADDR_CTRL_ONE);
   wire         sel_two     = (avs_address_in == ADDR_CTRL_TWO);
   wire         sel_pri     = (avs_address_in == ADDR_PRIMARY);
   wire         sel_sec     = (avs_address_in == ADDR_SECONDARY);
   wire         wr_ctrl     = wr_go & sel_ctrl;
   wire         wr_two      = wr_go & sel_two;
   wire         wr_pri      = wr_go & sel_pri;
   wire         wr_sec      = wr_go & sel_sec;
   wire [15:0]  lane_mask   = {{8{hi_en}}, {8{lo_en}}};
   wire [15:0]  wdata       = avs_writedata_in[15:0];

   // Register updates with byte lanes
   wire [15:0]  ctrl_upd    = (ctrl_ff & ~lane_mask) | (wdata & lane_mask);
   wire [15:0]  pri_upd     = (primary_ff & ~lane_mask) | (wdata & lane_mask);
   wire [15:0]  sec_upd     = (secondary_ff & ~lane_mask) | (wdata & lane_mask);

   // ------------------------------------------------------------
   // Mode decode
   // ------------------------------------------------------------
   wire [2:0]   mode        = ctrl_ff[MODE_MSB:MODE_LSB];
   wire         clr_mode    = ctrl_ff[TRIG_CLR_BIT];
   wire         is_pwm      = (mode == OCC_PWM_EDGE) | (mode == OCC_PWM_CENTER);
   // True for one clock only: prev_mode_ff trails ctrl_ff by one clock
   wire         enabling    = (prev_mode_ff == OCC_OFF) & (mode != OCC_OFF);
   // PWM period boundary: buffered values move to active at timer zero
   wire         pwm_reload  = is_pwm & cmp.hit_zero;
   wire         hit_p       = cmp.hit_primary;
   wire         hit_s       = cmp.hit_secondary;

   // Status cleared by software writing a zero to its bit
   // Hardware clears only in clear mode, on a secondary match of an enabled channel
   wire         sw_clear    = wr_two & lo_en & ~wdata[TRIG_STAT_BIT];
   wire         hw_clear    = clr_mode & hit_s & (mode != OCC_OFF);
   // Status set by the selected trigger clock pulse
   wire         trig_set    = trig_ff & (mode != OCC_OFF);

   // Only the active copies reach the matcher
   assign cmp.active_primary   = act_primary_ff;
   assign cmp.active_secondary = act_secondary_ff;

   // ------------------------------------------------------------
   // Compare engines and clock source
   // ------------------------------------------------------------
   // Equality only: a value above the timer's reach never matches
   occ_matcher u_match (
      .timer_count_in (timer_count_in),
      .cmp            (cmp.matcher)
   );

   // One fixed trigger line per channel, chosen by the CHANNEL parameter
   logic trig_sel;
   occ_clock_select #(.CHANNEL(CHANNEL)) u_csel (
      .trig_outputs_in (trig_outputs_in),
      .trig_pulse_out  (trig_sel)
   );

   // ------------------------------------------------------------
   // Pin behaviour per mode
   // ------------------------------------------------------------
   always_comb begin
      nxt_pin   = pin_ff;
      nxt_armed = armed_ff;
      nxt_phase = phase_ff;
      if (enabling) begin
         // Initial level on leaving disabled mode
         nxt_pin   = (mode == OCC_SHOT_LOW);
         nxt_armed = 1'b1;
         nxt_phase = 1'b0;
      end else begin
         // A change between two enabled modes keeps pin and phase as they are;
         // software passes through mode zero to restart a sequence
         unique case (mode)
            OCC_OFF: begin
               nxt_armed = 1'b0;
            end
            OCC_SHOT_HIGH: begin
               if (armed_ff && hit_p) begin
                  nxt_pin   = 1'b1;
                  nxt_armed = 1'b0;
               end
            end
            OCC_SHOT_LOW: begin
               if (armed_ff && hit_p) begin
                  nxt_pin   = 1'b0;
                  nxt_armed = 1'b0;
               end
            end
            // Toggles for as long as the mode stays selected
            OCC_TOGGLE: begin
               if (hit_p) begin
                  nxt_pin = ~pin_ff;
               end
            end
            // Armed drops after the pulse, so later matches are ignored until re-enabled
            OCC_DUAL_SHOT: begin
               if (armed_ff && !phase_ff && hit_p) begin
                  nxt_pin   = 1'b1;
                  nxt_phase = 1'b1;
               end else if (armed_ff && phase_ff && hit_s) begin
                  nxt_pin   = 1'b0;
                  nxt_phase = 1'b0;
                  nxt_armed = 1'b0;
               end
            end
            OCC_DUAL_CONT: begin
               if (!phase_ff && hit_p) begin
                  nxt_pin   = ~pin_ff;
                  nxt_phase = 1'b1;
               end else if (phase_ff && hit_s) begin
                  nxt_pin   = ~pin_ff;
                  nxt_phase = 1'b0;
               end
            end
            // Primary wins over zero, so a zero duty value keeps the pin low
            OCC_PWM_EDGE: begin
               if (hit_p) begin
                  nxt_pin = 1'b0;
               end else if (cmp.hit_zero) begin
                  nxt_pin = 1'b1;
               end
            end
            // Secondary wins, so equal values keep the pin low
            OCC_PWM_CENTER: begin
               if (hit_s) begin
                  nxt_pin = 1'b0;
               end else if (hit_p) begin
                  nxt_pin = 1'b1;
               end
            end
         endcase
      end
   end

   // Set wins over any clear arriving in the same cycle
   always_comb begin
      nxt_status = status_ff;
      if (sw_clear || hw_clear) begin
         nxt_status = 1'b0;
      end
      if (trig_set) begin
         nxt_status = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Registers written by software
   // ------------------------------------------------------------
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ctrl_ff      <= CTRL_RESET;
         primary_ff   <= VALUE_RESET;
         secondary_ff <= VALUE_RESET;
         prev_mode_ff <= OCC_OFF;
      end else begin
         prev_mode_ff <= ctrl_ff[MODE_MSB:MODE_LSB];
         if (wr_ctrl) ctrl_ff <= ctrl_upd;
         if (wr_pri) primary_ff <= pri_upd;
         if (wr_sec) secondary_ff <= sec_upd;
      end
   end

   // Active values: direct outside PWM, period-aligned inside it
   // Outside PWM the active copy trails the written value by one clock;
   // in PWM new values wait for timer zero so no period is cut short
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         act_primary_ff   <= VALUE_RESET;
         act_secondary_ff <= VALUE_RESET;
      end else if (!is_pwm || pwm_reload) begin
         act_primary_ff   <= primary_ff;
         act_secondary_ff <= secondary_ff;
      end
   end

   // ------------------------------------------------------------
   // Channel state
   // ------------------------------------------------------------
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pin_ff    <= 1'b0;
         armed_ff  <= 1'b0;
         phase_ff  <= 1'b0;
         status_ff <= 1'b0;
         trig_ff   <= 1'b0;
      end else begin
         pin_ff    <= nxt_pin;
         armed_ff  <= nxt_armed;
         phase_ff  <= nxt_phase;
         status_ff <= nxt_status;
         trig_ff   <= trig_sel;
      end
   end

   // ------------------------------------------------------------
   // Bus answer: one wait cycle, then acknowledge
   // ------------------------------------------------------------
   // Status word: pin, armed, trigger status and the fixed channel number
   wire [15:0] status_word =
      {6'h00, 2'(CHANNEL), 1'b0, status_ff, 4'h0, armed_ff, pin_ff};
   // Read data is captured on the taking edge and held until the next read
   wire [31:0] rd_mux =
      sel_ctrl ? {16'h0000, ctrl_ff} :
      sel_two  ? {16'h0000, status_word} :
      sel_pri  ? {16'h0000, primary_ff} :
      sel_sec  ? {16'h0000, secondary_ff} : 32'h0000_0000;

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ack_ff   <= 1'b0;
         wait_ff  <= 1'b1;
         rdata_ff <= 32'h0000_0000;
      end else begin
         // Waitrequest is low for exactly the one answer clock
         ack_ff   <= acc_go;
         wait_ff  <= ~acc_go;
         if (acc_go && avs_read_in) rdata_ff <= rd_mux;
      end
   end

   assign avs_waitrequest_out    = wait_ff;
   assign avs_readdata_out       = rdata_ff;
   assign compare_output_pin_out = pin_ff;
   assign trigger_status_flag_out = status_ff;
   assign trigger_clock_out      = trig_ff;

endmodule : occ_channel

// File: dv/occ_channel_assertions.sv
`timescale 1ns/100ps
module occ_channel_assertions
   import occ_pkg::*;
#(
   parameter int CHANNEL = 0
)(
   // Clock and reset
   input  wire logic        clock_in,
   input  wire logic        rstn_in,
   // Register bus
   input  wire logic [3:0]  avs_address_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic        avs_waitrequest_out,
   // Timer, trigger and outputs
   input  wire logic [15:0] timer_count_in,
   input  wire logic [15:0] trig_outputs_in,
   input  wire logic        compare_output_pin_out,
   input  wire logic        trigger_status_flag_out,
   input  wire logic        trigger_clock_out
);
   // ----------------------------------------
   // Shadow of the software settings
   // ----------------------------------------
   logic [3:0]  ctl_ff;
   logic [15:0] prm_ff;
   logic [15:0] sec_ff;
   logic [15:0] act_p_ff;
   logic [15:0] act_s_ff;
   // Writes land at the answer edge, where waitrequest is sampled low
   wire         tk      = avs_write_in && !avs_waitrequest_out;
   wire         wr_stat = tk && (avs_address_in == ADDR_CTRL_TWO);
   wire [3:0]   nxt_ctl = (tk && avs_address_in == ADDR_CTRL_ONE) ? avs_writedata_in[3:0] : ctl_ff;
   wire [15:0]  nxt_prm = (tk && avs_address_in == ADDR_PRIMARY) ? avs_writedata_in[15:0] : prm_ff;
   wire [15:0]  nxt_sec = (tk && avs_address_in == ADDR_SECONDARY) ? avs_writedata_in[15:0] : sec_ff;
   wire [2:0]   mode    = ctl_ff[2:0];
   wire         pin     = compare_output_pin_out;
   wire         flag    = trigger_status_flag_out;
   wire         sel     = trig_outputs_in[4 + CHANNEL];
   wire [15:0]  tmr     = timer_count_in;
   // Shadow registers
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ctl_ff <= 4'h0;
         prm_ff <= 16'h0000;
         sec_ff <= 16'h0000;
         act_p_ff <= 16'h0000;
         act_s_ff <= 16'h0000;
      end else begin
         ctl_ff <= nxt_ctl;
         prm_ff <= nxt_prm;
         sec_ff <= nxt_sec;
         // Values in use: held to the period start in PWM, one clock behind otherwise
         if (mode < 3'h6 || tmr == 16'h0000) begin
            act_p_ff <= prm_ff;
            act_s_ff <= sec_ff;
         end
      end
   end
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rstn_in);
   // Four clocks in one mode flush matches still pending from an older mode
   sequence s_held(logic [2:0] m);
      (mode == m)[*4];
   endsequence
   sequence s_enable;
      (mode == 3'h1 || mode == 3'h2) && $past(mode) == 3'h0;
   endsequence
   a_trig_follow: assert property ($past(rstn_in) |-> trigger_clock_out == $past(sel))
      else $error("trigger clock differs from selected line");
   a_off_hold: assert property (s_held(3'h0) |-> $stable(pin))
      else $error("pin moved while disabled");
   a_shot_high: assert property (s_held(3'h1) ##0 pin ##1 mode == 3'h1 |-> pin)
      else $error("pin fell after single shot high");
   a_shot_low: assert property (s_held(3'h2) ##0 !pin ##1 mode == 3'h2 |-> !pin)
      else $error("pin rose after single shot low");
   a_init_level: assert property (s_enable |-> ##[1:3] pin == mode[1])
      else $error("initial level not loaded");
   a_edge_zero: assert property (s_held(3'h6) ##0 (tmr == 16'h0 && act_p_ff != 16'h0) |-> ##[1:2] pin)
      else $error("edge pwm not high after zero");
   a_center_hi: assert property (s_held(3'h7) ##0 (tmr == act_p_ff && act_p_ff != act_s_ff) |-> ##[1:2] pin)
      else $error("center pwm not high after primary match");
   a_toggle_hit: assert property (s_held(3'h3) ##0 tmr == act_p_ff |-> ##[1:2] $changed(pin))
      else $error("pin did not toggle on match");
   a_flag_keep: assert property (!ctl_ff[3] && flag && !wr_stat |=> flag)
      else $error("status flag cleared by hardware");
   a_flag_clr: assert property (ctl_ff[3] && mode != 3'h0 && tmr == act_s_ff && !trigger_clock_out |-> ##[1:2] !flag)
      else $error("status flag not cleared on secondary match");
endmodule : occ_channel_assertions

bind occ_channel occ_channel_assertions #(.CHANNEL(CHANNEL)) u_occ_chk (
   .clock_in(clock_in), .rstn_in(rstn_in), .avs_address_in(avs_address_in),
   .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
   .avs_waitrequest_out(avs_waitrequest_out), .timer_count_in(timer_count_in),
   .trig_outputs_in(trig_outputs_in), .compare_output_pin_out(compare_output_pin_out),
   .trigger_status_flag_out(trigger_status_flag_out), .trigger_clock_out(trigger_clock_out));

// File: dv/occ_tb.sv
`timescale 1ns/100ps
module tb;
   import occ_pkg::*;
   typedef struct {string nm; logic [31:0] v;} occ_note_s;
   localparam int CH = 1;
   // Pin per mode at timer 2, 28, 58 over two periods after enable
   localparam logic [5:0] TAB [1:7] = '{6'h1f, 6'h20, 6'h1c, 6'h10, 6'h12, 6'h24, 6'h12};
   logic        clock_in = 1'b0;
   logic        rstn_in  = 1'b0;
   logic        rd = 1'b0, wr = 1'b0, probe = 1'b0, psel = 1'b0, pulse = 1'b0, pclk = 1'b0;
   logic [3:0]  adr = 4'h0, be = 4'h0;
   logic [31:0] wd = 32'h0, rdata;
   logic [15:0] tmr = 16'h0, trig = 16'h0, p, s;
   logic        wreq, pin, flag, tclk;
   occ_note_s   q[$];
   occ_note_s   nt;
   int          fails = 0, checked = 0;

   always #4 clock_in = ~clock_in;
   // Free-running timer, period of 80 counts
   always @(posedge clock_in) tmr <= (tmr == 16'h4f) ? 16'h0 : tmr + 16'h1;
   // Noise on other trigger lines; the selected one only pulses on demand
   always @(posedge clock_in) trig <= (16'($urandom) & ~(16'h0010 << CH)) | (16'(pulse) << (4 + CH));

   occ_channel #(.CHANNEL(CH)) u_dut (
      .clock_in(clock_in), .rstn_in(rstn_in), .avs_address_in(adr), .avs_read_in(rd),
      .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be), .avs_readdata_out(rdata),
      .avs_waitrequest_out(wreq), .timer_count_in(tmr), .trig_outputs_in(trig),
      .compare_output_pin_out(pin), .trigger_status_flag_out(flag), .trigger_clock_out(tclk));

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic complete_run;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : complete_run

   // Bus master: request held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge clock_in);
      adr <= a;
      wr <= w;
      rd <= ~w;
      wd <= {16'h0, d};
      be <= 4'h3;
      do begin
         @(posedge clock_in);
         n++;
      end while (wreq !== 1'b0 && n < 40);
      wr <= 1'b0;
      rd <= 1'b0;
      if (n >= 40) begin
         fails++;
         complete_run();
      end
   endtask : bus

   task automatic rd_exp(input string nm, input logic [3:0] a, input logic [31:0] e);
      q.push_back('{nm, e});
      bus(1'b0, a, 16'h0);
   endtask : rd_exp

   // Bounded wait for a timer value
   task automatic wait_t(input logic [15:0] v);
      int n;
      n = 0;
      do begin
         @(posedge clock_in);
         n++;
      end while (tmr !== v && n < 200);
      if (n >= 200) begin
         fails++;
         complete_run();
      end
   endtask : wait_t

   task automatic look(input string nm, input logic which, input logic e);
      q.push_back('{nm, {31'h0, e}});
      psel <= which;
      probe <= 1'b1;
      @(posedge clock_in);
      probe <= 1'b0;
      @(posedge clock_in);
   endtask : look

   // Trigger clock output, sampled two clocks after the pulse on the selected line
   task automatic look_clk(input logic e);
      q.push_back('{"trigger clock", {31'h0, e}});
      pclk <= 1'b1;
      probe <= 1'b1;
      @(posedge clock_in);
      probe <= 1'b0;
      pclk <= 1'b0;
      @(posedge clock_in);
   endtask : look_clk

   // Primary rewritten early in the period: held back in PWM, direct otherwise
   task automatic buf_case(input logic [2:0] m, input logic e1, input logic e2);
      bus(1'b1, ADDR_CTRL_ONE, 16'h0);
      bus(1'b1, ADDR_PRIMARY, 16'h14);
      bus(1'b1, ADDR_SECONDARY, 16'h2d);
      wait_t(16'h40);
      bus(1'b1, ADDR_CTRL_ONE, {13'h0, m});
      wait_t(16'h2);
      bus(1'b1, ADDR_PRIMARY, 16'h28);
      wait_t(16'h1c);
      look("pin", 1'b0, e1);
      wait_t(16'h1c);
      look("pin", 1'b0, e2);
      $display("test buffering mode %0d done", m);
   endtask : buf_case

   // Results are compared in arrival order as they appear
   always @(posedge clock_in) begin
      if (((rd || wr) && wreq === 1'b0 && rd) || probe) begin
         if (q.size() > 0) begin
            nt = q.pop_front();
            check(nt.nm, probe ? {31'h0, pclk ? tclk : (psel ? flag : pin)} : rdata, nt.v);
         end
      end
   end

   initial begin
      void'($urandom(27));
      repeat (3) @(posedge clock_in);
      rstn_in <= 1'b1;
      rd_exp("ctrl", ADDR_CTRL_ONE, 32'h0);
      rd_exp("status", ADDR_CTRL_TWO, 32'(CH) << SRC_LSB);
      bus(1'b1, 4'h2, 16'hffff);
      rd_exp("unmapped", 4'h2, 32'h0);
      bus(1'b1, ADDR_CTRL_ONE, 16'h0008);
      rd_exp("ctrl", ADDR_CTRL_ONE, 32'h8);
      $display("test registers done");
      for (int i = 1; i < 8; i++) begin
         bus(1'b1, ADDR_CTRL_ONE, 16'h0);
         bus(1'b1, ADDR_CTRL_TWO, 16'h0);
         p = 16'h8 + 16'($urandom % 13);
         s = 16'h24 + 16'($urandom % 15);
         bus(1'b1, ADDR_PRIMARY, p);
         bus(1'b1, ADDR_SECONDARY, s);
         if (i > 1) begin
            wait_t(16'h2);
            look("held pin", 1'b0, TAB[i-1][0]);
         end
         wait_t(16'h40);
         bus(1'b1, ADDR_CTRL_ONE, {12'h0, 1'(i), 3'(i)});
         for (int k = 0; k < 2; k++) begin
            wait_t(16'h2);
            look("pin", 1'b0, TAB[i][5-3*k]);
            wait_t(16'h1c);
            look("pin", 1'b0, TAB[i][4-3*k]);
            pulse <= (k == 0);
            @(posedge clock_in);
            pulse <= 1'b0;
            @(posedge clock_in);
            look_clk(k == 0);
            wait_t(16'h3a);
            look("pin", 1'b0, TAB[i][3-3*k]);
            if (k == 0) look("flag", 1'b1, ~1'(i));
         end
         $display("test mode %0d done", i);
      end
      buf_case(3'h6, 1'b0, 1'b1);
      buf_case(3'h1, 1'b0, 1'b1);
      complete_run();
   end
endmodule : tb
